// >>> axis_loop_pkg.sv
// Constants and carrier types for the axis position loop
package axis_loop_pkg;
  // ==========================================================================
  // Sizes
  localparam int NUM_AXES = 32;
  localparam int AXIS_W = 5;
  localparam int POS_W = 32;
  localparam int GAIN_W = 24;
  localparam int GAIN_FRAC = 16;
  localparam int PCNT_W = 17;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [AXIS_W-1:0] LAST_AXIS = 5'h1f;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BASE_PERIOD_NS = 500_000;
  localparam int BASE_PERIOD_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PERIOD_0P5MS = 2'h0;
  localparam logic [1:0] PERIOD_1MS = 2'h1;
  localparam logic [1:0] PERIOD_2MS = 2'h2;
  localparam logic [1:0] PERIOD_4MS = 2'h3;

  // ==========================================================================
  // Gains, unsigned Q8.16
  localparam logic [GAIN_W-1:0] GAIN_P_RESET = 24'h00_199a;
  localparam logic [GAIN_W-1:0] GAIN_ZERO = 24'h00_0000;

  // ==========================================================================
  // Origin search and position latch codes
  localparam logic [1:0] HOME_MODE_INPUT = 2'h0;
  localparam logic [1:0] HOME_MODE_MARKER = 2'h1;
  localparam logic [1:0] HOME_MODE_BOTH = 2'h2;
  localparam logic [1:0] HOME_IDLE = 2'h0;
  localparam logic [1:0] HOME_SEEK_INPUT = 2'h1;
  localparam logic [1:0] HOME_SEEK_MARKER = 2'h2;
  localparam logic LATCH_SRC_MARKER = 1'h0;
  localparam logic LATCH_SRC_INPUT = 1'h1;
  localparam logic LATCH_EDGE_RISE = 1'h0;
  localparam logic LATCH_EDGE_FALL = 1'h1;

  // ==========================================================================
  // Types
  typedef logic [POS_W-1:0] pos_t;
  typedef logic signed [POS_W-1:0] spos_t;
  typedef logic [AXIS_W-1:0] axis_t;
  typedef logic [PCNT_W-1:0] pcnt_t;
  typedef enum logic [1:0] {SEQ_WAIT = 2'b01, SEQ_AXIS = 2'b10} seq_state_t;
  typedef struct packed {
    logic [GAIN_W-1:0] kp;
    logic [GAIN_W-1:0] ki;
    logic [GAIN_W-1:0] kd;
    logic [GAIN_W-1:0] kov;
    logic [GAIN_W-1:0] kvff;
  } gains_t;
  typedef struct packed {
    pos_t accel;
    pos_t speed;
    pos_t jog_slow;
    pos_t jog_fast;
  } profile_cfg_t;
  typedef struct packed {logic valid; axis_t axis; pos_t distance;} move_cmd_t;
  typedef struct packed {logic valid; axis_t axis;} axis_cmd_t;
  typedef struct packed {logic valid; axis_t axis; logic [1:0] mode;} home_cmd_t;
  typedef struct packed {logic valid; axis_t axis; logic src; logic edge_sel;} latch_cmd_t;
endpackage

// >>> axis_position_loop.sv
// Multi-axis motion sequencer, profile generator and five-term position loop
// Operation
// - Abort drops the current move of one axis; halt drops moves on every axis.
// - An aborted axis ramps to rest at its own deceleration rate.
// - Origin search uses an input level, the index marker, or both.
// - Armed latch captures axis position on the chosen edge of marker or input.
// - Blend flag set chains the next queued move without stopping; clear stops first.
// - Jog inputs drive constant speed forward or reverse; select picks fast speed.
// - Following error is demand position minus measured position, fed to the loop.
// - Proportional term is proportional gain times following error.
// - Integral term is integral gain times accumulated following error.
// - Derivative term is derivative gain times change of following error.
// - Damping term is damping gain times change of measured position.
// - Feedforward term is feedforward gain times change of demand position.
// - Gains reset to 0.1 proportional and zero otherwise; fractional values held.
// - Computed speed reference is driven to the servo driver.
// - Each sequence visits all 32 axes: buffer, sample, profile, loop, output, errors.
// - Issued move commands enter the motion buffer; execution starts when the sequence next visits that axis.
// - A finished move leaves the buffer so the next entry proceeds.
// - The sequence repeats every 0.5, 1, 2 or 4 ms.
module axis_position_loop #(
  parameter int PERIOD_CYCLES = axis_loop_pkg::BASE_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] period_sel,
  input wire logic gain_wr,
  input wire axis_loop_pkg::gains_t gains_in,
  input wire axis_loop_pkg::profile_cfg_t profile_cfg,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] rate_a,
  input wire logic [axis_loop_pkg::POS_W-1:0] following_error_limit,
  input wire axis_loop_pkg::move_cmd_t move_cmd,
  input wire axis_loop_pkg::axis_cmd_t abort_cmd,
  input wire logic halt_all_axes,
  input wire axis_loop_pkg::home_cmd_t home_search_cmd,
  input wire axis_loop_pkg::latch_cmd_t position_latch_cmd,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0] blend_moves_flag,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0] jog_positive_input,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0] jog_negative_input,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0] jog_speed_select,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0] home_input,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0] index_marker,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0] latch_input,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] measured_position,
  output logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] speed_reference,
  output logic ref_strobe,
  output logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] demand_position,
  output logic [axis_loop_pkg::NUM_AXES-1:0] buf_full,
  output logic [axis_loop_pkg::NUM_AXES-1:0] axis_busy,
  output logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] latched_position,
  output logic [axis_loop_pkg::NUM_AXES-1:0] latch_done,
  output logic [axis_loop_pkg::NUM_AXES-1:0] home_done,
  output logic [axis_loop_pkg::NUM_AXES-1:0] follow_fault
);
  localparam int NA = axis_loop_pkg::NUM_AXES;
  localparam int PW = axis_loop_pkg::POS_W;

  // ==========================================================================
  // State
  typedef struct packed {
    axis_loop_pkg::seq_state_t state;
    axis_loop_pkg::pcnt_t period_cnt;
    logic [1:0] sel;
    logic sel_loaded;
    axis_loop_pkg::axis_t ax;
    axis_loop_pkg::gains_t gains;
    logic gains_set;
    logic ref_strobe;
    logic [NA-1:0][PW-1:0] dem_pos, vel, tgt, origin, err_prev, err_sum, meas_prev;
    logic [NA-1:0][PW-1:0] sref, latched_pos, pos_s1, pos_s2;
    logic [NA-1:0][1:0][PW-1:0] buf_dist;
    logic [NA-1:0][1:0] buf_cnt, home_phase;
    logic [NA-1:0] started, aborting, buf_full, busy, fault, home_both, home_done, marker_hit;
    logic [NA-1:0] latch_armed, latch_src, latch_edge, latch_done;
    logic [NA-1:0] jp_s1, jp_s2, jn_s1, jn_s2, jf_s1, jf_s2, hi_s1, hi_s2;
    logic [NA-1:0] ix_s1, ix_s2, ix_s3, li_s1, li_s2, li_s3;
  } state_t;

  state_t q, n;
  axis_loop_pkg::axis_t a;
  axis_loop_pkg::pcnt_t period_lim;
  axis_loop_pkg::spos_t meas, dp, v, tgt, rem, err, d_err, d_meas, d_dem;
  axis_loop_pkg::pos_t vmag, rem_abs, rate;
  logic signed [63:0] acc, gp, gi, gd, gov, gvff;
  logic [63:0] stop_lhs, stop_rhs;
  logic started, stop_need, wrong_way, home_found, blend_next, lev_now, lev_old, hit, drop;

  function automatic axis_loop_pkg::pos_t mag(input axis_loop_pkg::spos_t x);
    return (x < 0) ? axis_loop_pkg::pos_t'(-x) : axis_loop_pkg::pos_t'(x);
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    n = q;
    a = q.ax;
    meas = '0; dp = '0; v = '0; tgt = '0; rem = '0; err = '0;
    d_err = '0; d_meas = '0; d_dem = '0; vmag = '0; rem_abs = '0; rate = '0;
    stop_lhs = '0; stop_rhs = '0; acc = '0;
    started = 1'b0; stop_need = 1'b0; wrong_way = 1'b0; home_found = 1'b0;
    blend_next = 1'b0; lev_now = 1'b0; lev_old = 1'b0; hit = 1'b0; drop = 1'b0;
    gp = {40'h00_0000_0000, q.gains.kp};
    gi = {40'h00_0000_0000, q.gains.ki};
    gd = {40'h00_0000_0000, q.gains.kd};
    gov = {40'h00_0000_0000, q.gains.kov};
    gvff = {40'h00_0000_0000, q.gains.kvff};
    period_lim = axis_loop_pkg::pcnt_t'((PERIOD_CYCLES << q.sel) - 1);

    // Synchronisers
    n.pos_s1 = measured_position;
    n.pos_s2 = q.pos_s1;
    n.jp_s1 = jog_positive_input;
    n.jp_s2 = q.jp_s1;
    n.jn_s1 = jog_negative_input;
    n.jn_s2 = q.jn_s1;
    n.jf_s1 = jog_speed_select;
    n.jf_s2 = q.jf_s1;
    n.hi_s1 = home_input;
    n.hi_s2 = q.hi_s1;
    n.ix_s1 = index_marker;
    n.ix_s2 = q.ix_s1;
    n.ix_s3 = q.ix_s2;
    n.li_s1 = latch_input;
    n.li_s2 = q.li_s1;
    n.li_s3 = q.li_s2;
    n.ref_strobe = 1'b0;

    // Period select is taken once after reset
    if (!q.sel_loaded) begin
      n.sel = period_sel;
      n.sel_loaded = 1'b1;
    end
    if (gain_wr) begin
      n.gains = gains_in;
      n.gains_set = 1'b1;
    end
    if (q.period_cnt == period_lim) begin
      n.period_cnt = '0;
    end else begin
      n.period_cnt = q.period_cnt + 1'b1;
    end

    // ========================================================================
    // Motion sequence, one axis per clock
    unique case (q.state)
      axis_loop_pkg::SEQ_WAIT: begin
        if (q.sel_loaded && q.period_cnt == period_lim) begin
          n.state = axis_loop_pkg::SEQ_AXIS;
          n.ax = '0;
        end
      end
      axis_loop_pkg::SEQ_AXIS: begin
        if (q.ax == axis_loop_pkg::LAST_AXIS) begin
          n.state = axis_loop_pkg::SEQ_WAIT;
          n.ref_strobe = 1'b1;
        end else begin
          n.ax = q.ax + 1'b1;
        end
        meas = q.pos_s2[a] - q.origin[a];
        dp = q.dem_pos[a];
        v = q.vel[a];
        rate = rate_a[a];
        tgt = q.tgt[a];
        started = q.started[a];
        blend_next = blend_moves_flag[a] && q.buf_cnt[a] > 2'h1;
        // Read the buffer
        if (!started && q.buf_cnt[a] != 2'h0 && !q.aborting[a] &&
            q.home_phase[a] == axis_loop_pkg::HOME_IDLE) begin
          tgt = dp + q.buf_dist[a][0];
          started = 1'b1;
        end
        // Profile
        if (q.aborting[a] || (!started && q.home_phase[a] == axis_loop_pkg::HOME_IDLE &&
            !(q.jp_s2[a] ^ q.jn_s2[a]))) begin
          vmag = mag(v);
          vmag = (vmag > rate) ? vmag - rate : '0;
          v = (v < 0) ? -vmag : vmag;
          if (q.aborting[a] && vmag == '0) begin
            n.aborting[a] = 1'b0;
          end
        end else if (q.home_phase[a] != axis_loop_pkg::HOME_IDLE) begin
          v = -profile_cfg.jog_slow;
          if (q.home_phase[a] == axis_loop_pkg::HOME_SEEK_INPUT && q.hi_s2[a]) begin
            if (q.home_both[a]) begin
              n.home_phase[a] = axis_loop_pkg::HOME_SEEK_MARKER;
              n.marker_hit[a] = 1'b0;
            end else begin
              home_found = 1'b1;
            end
          end else if (q.home_phase[a] == axis_loop_pkg::HOME_SEEK_MARKER && q.marker_hit[a]) begin
            home_found = 1'b1;
          end
        end else if (started) begin
          rem = tgt - dp;
          rem_abs = mag(rem);
          vmag = mag(v);
          wrong_way = (v != 0) && ((v < 0) != (rem < 0));
          stop_lhs = ({32'h0000_0000, rem_abs} * {32'h0000_0000, rate}) << 1;
          stop_rhs = {32'h0000_0000, vmag} * {32'h0000_0000, vmag};
          stop_need = !(blend_moves_flag[a] && blend_next) && stop_lhs <= stop_rhs;
          if (wrong_way) begin
            vmag = (vmag > rate) ? vmag - rate : '0;
            v = (v < 0) ? -vmag : vmag;
          end else begin
            if (stop_need) begin
              vmag = (vmag > rate) ? vmag - rate : ((rem_abs < rate) ? rem_abs : rate);
            end else if (vmag < profile_cfg.speed) begin
              vmag = (profile_cfg.speed - vmag > profile_cfg.accel) ?
                     vmag + profile_cfg.accel : profile_cfg.speed;
            end else begin
              vmag = profile_cfg.speed;
            end
            vmag = (vmag > rem_abs) ? rem_abs : vmag;
            v = (rem < 0) ? -vmag : vmag;
          end
        end else begin
          v = q.jf_s2[a] ? profile_cfg.jog_fast : profile_cfg.jog_slow;
          v = q.jn_s2[a] ? -v : v;
        end
        dp = dp + v;
        // Finished move leaves the buffer
        if (started && q.home_phase[a] == axis_loop_pkg::HOME_IDLE && !q.aborting[a] &&
            dp == tgt) begin
          n.buf_dist[a][0] = q.buf_dist[a][1];
          n.buf_cnt[a] = q.buf_cnt[a] - 2'h1;
          started = 1'b0;
          if (blend_moves_flag[a] && q.buf_cnt[a] > 2'h1) begin
            tgt = dp + q.buf_dist[a][1];
            started = 1'b1;
          end else begin
            v = '0;
          end
        end
        // Position loop
        err = dp - meas;
        d_err = err - axis_loop_pkg::spos_t'(q.err_prev[a]);
        d_meas = meas - axis_loop_pkg::spos_t'(q.meas_prev[a]);
        d_dem = dp - axis_loop_pkg::spos_t'(q.dem_pos[a]);
        n.err_sum[a] = q.err_sum[a] + err;
        acc = gp * 64'(err)
            + gi * 64'(axis_loop_pkg::spos_t'(n.err_sum[a]))
            + gd * 64'(d_err)
            - gov * 64'(d_meas)
            + gvff * 64'(d_dem);
        n.sref[a] = acc[axis_loop_pkg::GAIN_FRAC +: PW];
        if (mag(err) > following_error_limit) begin
          n.fault[a] = 1'b1;
        end
        n.dem_pos[a] = dp;
        n.vel[a] = v;
        n.tgt[a] = tgt;
        n.started[a] = started;
        n.err_prev[a] = err;
        n.meas_prev[a] = meas;
        if (home_found) begin
          n.home_phase[a] = axis_loop_pkg::HOME_IDLE;
          n.home_done[a] = 1'b1;
          n.origin[a] = q.pos_s2[a];
          n.dem_pos[a] = '0;
          n.vel[a] = '0;
          n.err_sum[a] = '0;
          n.err_prev[a] = '0;
          n.meas_prev[a] = '0;
          n.sref[a] = '0;
        end
      end
    endcase

    // ========================================================================
    // Commands
    for (int i = 0; i < NA; i++) begin
      drop = halt_all_axes || (abort_cmd.valid && abort_cmd.axis == axis_loop_pkg::axis_t'(i));
      if (drop) begin
        n.aborting[i] = 1'b1;
        n.buf_cnt[i] = 2'h0;
        n.started[i] = 1'b0;
        n.home_phase[i] = axis_loop_pkg::HOME_IDLE;
        n.fault[i] = n.fault[i] && !q.fault[i];
      end
    end
    if (home_search_cmd.valid && !n.aborting[home_search_cmd.axis]) begin
      n.home_phase[home_search_cmd.axis] = (home_search_cmd.mode == axis_loop_pkg::HOME_MODE_MARKER) ?
          axis_loop_pkg::HOME_SEEK_MARKER : axis_loop_pkg::HOME_SEEK_INPUT;
      n.home_both[home_search_cmd.axis] = home_search_cmd.mode == axis_loop_pkg::HOME_MODE_BOTH;
      n.home_done[home_search_cmd.axis] = 1'b0;
      n.marker_hit[home_search_cmd.axis] = 1'b0;
      n.buf_cnt[home_search_cmd.axis] = 2'h0;
      n.started[home_search_cmd.axis] = 1'b0;
    end
    if (move_cmd.valid && !q.buf_full[move_cmd.axis] && !halt_all_axes &&
        !(abort_cmd.valid && abort_cmd.axis == move_cmd.axis) &&
        n.home_phase[move_cmd.axis] == axis_loop_pkg::HOME_IDLE) begin
      n.buf_dist[move_cmd.axis][n.buf_cnt[move_cmd.axis][0]] = move_cmd.distance;
      n.buf_cnt[move_cmd.axis] = n.buf_cnt[move_cmd.axis] + 2'h1;
    end
    if (position_latch_cmd.valid) begin
      n.latch_armed[position_latch_cmd.axis] = 1'b1;
      n.latch_src[position_latch_cmd.axis] = position_latch_cmd.src;
      n.latch_edge[position_latch_cmd.axis] = position_latch_cmd.edge_sel;
      n.latch_done[position_latch_cmd.axis] = 1'b0;
    end

    // ========================================================================
    // Hardware latch, marker watch and status, every clock
    for (int i = 0; i < NA; i++) begin
      lev_now = (q.latch_src[i] == axis_loop_pkg::LATCH_SRC_INPUT) ? q.li_s2[i] : q.ix_s2[i];
      lev_old = (q.latch_src[i] == axis_loop_pkg::LATCH_SRC_INPUT) ? q.li_s3[i] : q.ix_s3[i];
      hit = (q.latch_edge[i] == axis_loop_pkg::LATCH_EDGE_FALL) ? (lev_old && !lev_now) :
            (lev_now && !lev_old);
      if (q.latch_armed[i] && hit) begin
        n.latched_pos[i] = q.pos_s2[i] - q.origin[i];
        n.latch_done[i] = 1'b1;
        n.latch_armed[i] = 1'b0;
      end
      if (n.home_phase[i] == axis_loop_pkg::HOME_SEEK_MARKER && q.ix_s2[i] && !q.ix_s3[i]) begin
        n.marker_hit[i] = 1'b1;
      end
      n.buf_full[i] = n.buf_cnt[i] == axis_loop_pkg::BUF_DEPTH;
      n.busy[i] = n.started[i] || n.buf_cnt[i] != 2'h0 || n.aborting[i] ||
                  n.home_phase[i] != axis_loop_pkg::HOME_IDLE;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.state <= axis_loop_pkg::SEQ_WAIT;
      q.gains <= '{axis_loop_pkg::GAIN_P_RESET, axis_loop_pkg::GAIN_ZERO, axis_loop_pkg::GAIN_ZERO,
                   axis_loop_pkg::GAIN_ZERO, axis_loop_pkg::GAIN_ZERO};
    end else begin
      q <= n;
    end
  end

  assign speed_reference = q.sref;
  assign ref_strobe = q.ref_strobe;
  assign demand_position = q.dem_pos;
  assign buf_full = q.buf_full;
  assign axis_busy = q.busy;
  assign latched_position = q.latched_pos;
  assign latch_done = q.latch_done;
  assign home_done = q.home_done;
  assign follow_fault = q.fault;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_abort_drops_axis: assert property (abort_cmd.valid |=>
    q.buf_cnt[$past(abort_cmd.axis)] == 2'h0 && q.aborting[$past(abort_cmd.axis)])
    else $error("abort did not drop the axis move");
  a_halt_drops_all: assert property (halt_all_axes |=> q.buf_cnt == '0 && &q.aborting)
    else $error("halt did not drop all moves");
  a_abort_ends_rest: assert property ((q.state == axis_loop_pkg::SEQ_AXIS &&
    q.aborting[q.ax] && !halt_all_axes && !abort_cmd.valid) |=>
    q.aborting[$past(q.ax)] || q.vel[$past(q.ax)] == '0)
    else $error("abort ended with axis still moving");
  a_jog_slow_speed: assert property ((q.state == axis_loop_pkg::SEQ_AXIS &&
    !q.aborting[q.ax] && !q.started[q.ax] && q.buf_cnt[q.ax] == 2'h0 &&
    q.home_phase[q.ax] == axis_loop_pkg::HOME_IDLE && q.jp_s2[q.ax] && !q.jn_s2[q.ax] &&
    !q.jf_s2[q.ax]) |=> q.vel[$past(q.ax)] == $past(profile_cfg.jog_slow))
    else $error("jog speed wrong");
  a_period_start: assert property ($rose(q.state == axis_loop_pkg::SEQ_AXIS) |->
    $past(q.period_cnt) == $past(period_lim))
    else $error("sequence started off the period");
  a_sequence_span: assert property ($rose(q.state == axis_loop_pkg::SEQ_AXIS) |->
    q.ax == '0 ##31 (q.state == axis_loop_pkg::SEQ_AXIS && q.ax == axis_loop_pkg::LAST_AXIS)
    ##1 q.state == axis_loop_pkg::SEQ_WAIT)
    else $error("sequence did not visit every axis");
  a_ref_strobe_end: assert property (q.ref_strobe |->
    $past(q.state) == axis_loop_pkg::SEQ_AXIS && $past(q.ax) == axis_loop_pkg::LAST_AXIS)
    else $error("reference strobe out of place");
  a_gain_defaults: assert property (!q.gains_set |-> q.gains.kp == axis_loop_pkg::GAIN_P_RESET &&
    q.gains.ki == '0 && q.gains.kd == '0 && q.gains.kov == '0 && q.gains.kvff == '0)
    else $error("gain defaults wrong");
  a_move_buffered: assert property ((move_cmd.valid && !q.buf_full[move_cmd.axis] &&
    !halt_all_axes && !abort_cmd.valid && !home_search_cmd.valid &&
    q.home_phase[move_cmd.axis] == axis_loop_pkg::HOME_IDLE) |=> q.buf_cnt[$past(move_cmd.axis)] != 2'h0)
    else $error("move command not buffered");
  for (genvar g = 0; g < NA; g++) begin : g_latch_chk
    a_latch_capture: assert property ($rose(q.latch_done[g]) |->
      q.latched_pos[g] == $past(q.pos_s2[g]) - $past(q.origin[g]))
      else $error("latched position wrong");
  end
  c_halt: cover property (halt_all_axes ##1 q.busy != '0);
  c_latch: cover property ($rose(q.latch_done[0]));
  c_home: cover property ($rose(q.home_done[0]));
  c_blend: cover property (q.started[0] && q.buf_cnt[0] == 2'h2 && blend_moves_flag[0]
    ##1 q.buf_cnt[0] == 2'h1 && q.started[0]);
endmodule

// >>> servo_driver_model.sv
// Servo driver and encoder model for every axis
module servo_driver_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ref_strobe,
  input wire logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] speed_reference,
  output logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] measured_position
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Position advances in proportion to the reference once per sequence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      measured_position <= '0;
    end else if (ref_strobe) begin
      for (int i = 0; i < axis_loop_pkg::NUM_AXES; i++) begin
        measured_position[i] <= measured_position[i] + 32'($signed(speed_reference[i]) >>> 1);
      end
    end
  end
endmodule

// >>> tb_axis_position_loop.sv
// Self-checking bench for the axis position loop
module tb_axis_position_loop;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 64;
  typedef logic [axis_loop_pkg::NUM_AXES-1:0][axis_loop_pkg::POS_W-1:0] bank_t;
  typedef logic [axis_loop_pkg::NUM_AXES-1:0] bits_t;
  logic clk = 0, rstn = 0, gain_wr = 0, halt = 0, strobe;
  axis_loop_pkg::gains_t gains_in = '0, g = '0;
  axis_loop_pkg::profile_cfg_t prof = '0;
  bank_t rate = '0, meas, spr, dem, lat, pm = '0, pd = '0;
  bits_t blend = '0, jp = '0, jn = '0, js = '0, hin = '0, imk = '0, lin = '0;
  bits_t bf, busy, ld, hd, ff, skip = '0;
  axis_loop_pkg::move_cmd_t mv = '0;
  axis_loop_pkg::axis_cmd_t ab = '0;
  axis_loop_pkg::home_cmd_t hm = '0;
  axis_loop_pkg::latch_cmd_t lc = '0;
  longint sum [32], pe [32], dlt [32], e, x, pv;
  int failures = 0, check_count = 0, seed = 43205, n3, n4;
  time last_t = 0;
  logic [1:0] psel = 2'h0;
  logic [31:0] fel = 32'h7fff_ffff;
  axis_position_loop #(.PERIOD_CYCLES(PC)) u_dut (.clk(clk), .rstn(rstn), .period_sel(psel),
    .gain_wr(gain_wr), .gains_in(gains_in), .profile_cfg(prof), .rate_a(rate),
    .following_error_limit(fel), .move_cmd(mv), .abort_cmd(ab), .halt_all_axes(halt),
    .home_search_cmd(hm), .position_latch_cmd(lc), .blend_moves_flag(blend),
    .jog_positive_input(jp), .jog_negative_input(jn), .jog_speed_select(js), .home_input(hin),
    .index_marker(imk), .latch_input(lin), .measured_position(meas), .speed_reference(spr),
    .ref_strobe(strobe), .demand_position(dem), .buf_full(bf), .axis_busy(busy),
    .latched_position(lat), .latch_done(ld), .home_done(hd), .follow_fault(ff));
  servo_driver_model u_drv (.clk(clk), .rstn(rstn), .ref_strobe(strobe),
    .speed_reference(spr), .measured_position(meas));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================================
  // Waits one sequence and checks every reference not marked in skip against the loop sum
  task automatic seq();
    for (int n = 0; n < (4 * PC << psel) && strobe !== 1'b1; n++) @(negedge clk);
    if (last_t != 0) chk($time - last_t, PC * 50 << psel);
    last_t = $time;
    for (int i = 0; i < 32; i++) begin
      e = longint'(axis_loop_pkg::spos_t'(dem[i] - meas[i]));
      dlt[i] = longint'(axis_loop_pkg::spos_t'(dem[i] - pd[i]));
      sum[i] = longint'(axis_loop_pkg::spos_t'(sum[i] + e));
      x = longint'(g.kp) * e + longint'(g.ki) * sum[i] + longint'(g.kd) * (e - pe[i])
        - longint'(g.kov) * longint'(axis_loop_pkg::spos_t'(meas[i] - pm[i]))
        + longint'(g.kvff) * dlt[i];
      if (!skip[i]) chk(spr[i], {32'h0000_0000, x[47:16]});
      pe[i] = e;
      pm[i] = meas[i];
      pd[i] = dem[i];
    end
    @(negedge clk);
  endtask
  initial begin
    #(40_000 * 50);
    failures++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < 32; i++) begin
      sum[i] = 0;
      pe[i] = 0;
      rate[i] = 32'h0004 + 32'($random(seed) & 7);
    end
    g.kp = axis_loop_pkg::GAIN_P_RESET;
    prof = '{32'h0008, 32'h0028, 32'h0005, 32'h000c};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({bf, busy}, 64'h0000);
    repeat (2) seq();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      blend <= 32'h0000_0008;
      mv <= '{1'b1, 5'(3 + k / 2), 32'h0190};
    end
    @(posedge clk);
    mv <= '0;
    @(negedge clk);
    chk({busy[4:3], bf[4:3]}, 64'h000f);
    n3 = 0;
    n4 = 0;
    for (int k = 0; k < 60; k++) begin
      n3 += busy[3];
      n4 += busy[4];
      seq();
    end
    chk({busy[4:3], n3 < n4}, 64'h0001);
    chk({dem[4], dem[3]}, 64'h0000_0320_0000_0320);
    g = '{24'($random(seed)) & 24'h01_ffff, 24'($random(seed)) & 24'h00_00ff,
      24'($random(seed)) & 24'h00_7fff, 24'($random(seed)) & 24'h00_7fff,
      24'($random(seed)) & 24'h01_ffff};
    @(posedge clk);
    gain_wr <= 1'b1;
    gains_in <= g;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      gain_wr <= 1'b0;
      mv <= '{1'b1, 5'(16 + ($random(seed) & 7)), 32'($random(seed) % 300)};
    end
    @(posedge clk);
    mv <= '0;
    repeat (20) seq();
    for (int k = 5; k < 8; k++) begin
      @(posedge clk);
      mv <= '{1'b1, 5'(k), 32'h0fa0};
    end
    @(posedge clk);
    mv <= '0;
    repeat (10) seq();
    @(posedge clk);
    ab <= '{1'b1, 5'd5};
    @(posedge clk);
    ab <= '0;
    for (int k = 0; k < 30 && busy[5] !== 1'b0; k++) begin
      pv = dlt[5];
      seq();
      chk(pv - dlt[5] <= rate[5] && dlt[5] <= pv, 64'h0001);
    end
    chk({busy[5], busy[6]}, 64'h0001);
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    repeat (20) seq();
    chk({busy[7:5], dem[6] < 32'h0fa0}, 64'h0001);
    @(posedge clk);
    jp[10] <= 1'b1;
    repeat (8) seq();
    chk(dlt[10], 64'h0005);
    @(posedge clk);
    js[10] <= 1'b1;
    repeat (4) seq();
    chk(dlt[10], 64'h000c);
    @(posedge clk);
    jp[10] <= 1'b0;
    repeat (8) seq();
    @(posedge clk);
    jn[10] <= 1'b1;
    repeat (8) seq();
    chk(-dlt[10], 64'h000c);
    for (int k = 0; k < 4; k++) begin
      seq();
      @(posedge clk);
      imk[11] <= k[0];
      lin[11] <= k[0];
      repeat (4) @(posedge clk);
      lc <= '{1'b1, 5'd11, k[1], k[0]};
      @(posedge clk);
      lc <= '0;
      if (k[1]) imk[11] <= ~k[0];
      else lin[11] <= ~k[0];
      repeat (6) @(posedge clk);
      chk(ld[11], 64'h0000);
      if (k[1]) lin[11] <= ~k[0];
      else imk[11] <= ~k[0];
      for (int n = 0; n < 10 && ld[11] !== 1'b1; n++) @(negedge clk);
      chk({ld[11], lat[11]}, {31'h0000_0000, 1'b1, meas[11]});
    end
    skip[14:12] = 3'b111;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      hm <= '{1'b1, 5'(12 + k), 2'(k)};
    end
    @(posedge clk);
    hm <= '0;
    repeat (3) seq();
    @(posedge clk);
    hin[14:12] <= 3'b101;
    repeat (2) seq();
    chk(hd[14:12], 64'h0001);
    @(posedge clk);
    imk[14:13] <= 2'b11;
    repeat (2) seq();
    chk({hd[14:12], dem[12] | dem[13] | dem[14]}, 64'h0007_0000_0000);
    @(posedge clk);
    fel <= 32'h0000_0000;
    seq();
    for (int i = 0; i < 32; i++) begin
      if (!skip[i]) chk(ff[i], pe[i] != 0);
    end
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    @(negedge clk);
    chk(ff, 64'h0000);
    @(posedge clk);
    rstn <= 1'b0;
    psel <= 2'h3;
    @(posedge clk);
    rstn <= 1'b1;
    g = '0;
    g.kp = axis_loop_pkg::GAIN_P_RESET;
    last_t = 0;
    skip = '0;
    pm = '0;
    pd = '0;
    for (int i = 0; i < 32; i++) begin
      sum[i] = 0;
      pe[i] = 0;
    end
    repeat (2) seq();
    report_and_stop();
  end
endmodule
